/* include/irq_ctrl_pkg.sv */
// Purpose: Shared constants for the nested vectored interrupt controller
// Assumes: 32-bit APB register bus, byte addresses as printed
// Notes:   Exception levels are encoded; a lower code is more urgent
package irq_ctrl_pkg;
  // Sizes
  localparam int unsigned LINES   = 32;  // External request lines
  localparam int unsigned NUM_EXC = 48;  // Exception numbers 0..47
  localparam int unsigned NUM_W   = 6;   // Exception number width
  localparam int unsigned LVL_W   = 3;   // Encoded level width
  localparam int unsigned PRIO_W  = 2;   // Stored priority bits
  localparam int unsigned FIELD_W = 8;   // Priority field in a register
  localparam int unsigned PRIO_REGS = 8; // Priority registers
  // Register byte addresses
  localparam logic [31:0] ENABLE_SET_ADDR = 32'he000e100;
  localparam logic [31:0] ENABLE_CLR_ADDR = 32'he000e180;
  localparam logic [31:0] PEND_SET_ADDR   = 32'he000e200;
  localparam logic [31:0] PEND_CLR_ADDR   = 32'he000e280;
  localparam logic [31:0] PRIO_BASE_ADDR  = 32'he000e400;
  localparam logic [31:0] PRIO_STEP       = 32'h00000004;
  localparam logic [31:0] SYS_PRIO_ADDR   = 32'he000ed20;
  localparam logic [31:0] STATUS_ADDR     = 32'he000ed04;
  // Exception numbers
  localparam int unsigned EXC_RESET   = 1;
  localparam int unsigned EXC_NMI     = 2;
  localparam int unsigned EXC_HARD    = 3;
  localparam int unsigned EXC_SVC     = 11;
  localparam int unsigned EXC_PENDABLE_SERVICE_EXCEPTION  = 14;
  localparam int unsigned EXC_SYSTEM_TICK_EXCEPTION = 15;
  localparam int unsigned EXC_EXT     = 16;
  // Encoded levels: fixed -3, -2, -1, then four settable, then idle
  localparam logic [2:0] LVL_RESET    = 3'h0;
  localparam logic [2:0] LVL_NMI      = 3'h1;
  localparam logic [2:0] LVL_HARD     = 3'h2;
  localparam logic [2:0] LVL_CFG_BASE = 3'h3;
  localparam logic [2:0] LVL_IDLE     = 3'h7;
  // Field positions
  localparam int unsigned SVC_BYTE      = 0;  // System priority bytes
  localparam int unsigned PENDABLE_SERVICE_EXCEPTION_BYTE   = 1;
  localparam int unsigned SYSTEM_TICK_EXCEPTION_BYTE  = 2;
  localparam int unsigned STAT_RUN_NUM  = 0;  // Status word fields
  localparam int unsigned STAT_RUN_LVL  = 8;
  localparam int unsigned STAT_WIN_NUM  = 16;
  localparam int unsigned STAT_WIN_OK   = 24;
  // Reset values
  localparam logic [31:0] ENABLE_RST = 32'h00000000;
  localparam logic [47:0] PEND_RST   = 48'h000000000002; // Reset pending
  localparam logic [1:0]  PRIO_RST   = 2'h0;
  // Register port states
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_ANSWER = 2'b10} port_state_t;
  // Vector slot offset of an exception number
  function automatic logic [31:0] vector_offset(input logic [5:0] num);
    return {24'h000000, num, 2'b00};
  endfunction
endpackage

/* logic/apb_reg_port.sv */
// Purpose: APB slave timing for the register file
// Assumes: Access phase gets exactly one wait state
// Notes:   Writes land at the edge where pready is sampled high
`timescale 1ns/1ps
module apb_reg_port (
  input  wire logic        clk_i,      // System clock
  input  wire logic        sys_rst_i,  // Synchronous reset
  input  wire logic        psel_i,     // APB select
  input  wire logic        penable_i,  // APB access phase
  input  wire logic        pwrite_i,   // APB direction
  input  wire logic [31:0] rdata_i,    // Read data of decoded register
  input  wire logic        hit_i,      // Address is mapped
  output logic [31:0]      prdata_o,   // Registered read data
  output logic             pready_o,   // Registered ready
  output logic             pslverr_o,  // Registered error
  output logic             wr_stb_o    // Write takes effect this edge
);
  irq_ctrl_pkg::port_state_t state;  // Idle or answering
  // Step through access phase
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state     <= irq_ctrl_pkg::ST_IDLE;
      pready_o  <= 1'b0;
      prdata_o  <= 32'h00000000;
      pslverr_o <= 1'b0;
    end else begin
      case (state)
        irq_ctrl_pkg::ST_IDLE: begin
          // First access cycle: capture answer
          if (psel_i && penable_i) begin
            state     <= irq_ctrl_pkg::ST_ANSWER;
            pready_o  <= 1'b1;
            prdata_o  <= (hit_i && !pwrite_i) ? rdata_i : 32'h00000000;
            pslverr_o <= !hit_i;
          end
        end
        irq_ctrl_pkg::ST_ANSWER: begin
          // Transfer completes at this edge
          state     <= irq_ctrl_pkg::ST_IDLE;
          pready_o  <= 1'b0;
          pslverr_o <= 1'b0;
        end
        default: begin
          state    <= irq_ctrl_pkg::ST_IDLE;
          pready_o <= 1'b0;
        end
      endcase
    end
  end
  // Mapped writes only, in the completing cycle
  assign wr_stb_o = (state == irq_ctrl_pkg::ST_ANSWER) && psel_i && penable_i && pwrite_i && hit_i;
endmodule

/* logic/level_arbiter.sv */
// Purpose: Picks the most urgent valid entry, lowest index on a tie
// Assumes: Lower level code means more urgent
// Notes:   Purely combinational; used for winner and running search
`timescale 1ns/1ps
module level_arbiter #(
  parameter int unsigned N  = 48,  // Entries
  parameter int unsigned LW = 3,   // Level width
  parameter int unsigned IW = 6    // Index width
) (
  input  wire logic [N-1:0]    valid_i,  // Entry takes part
  input  wire logic [N*LW-1:0] level_i,  // Packed levels
  output logic                 found_o,  // Any entry valid
  output logic [IW-1:0]        index_o,  // Winning entry
  output logic [LW-1:0]        level_o   // Winning level
);
  // Scan from the top so lower indices win ties
  always_comb begin
    found_o = 1'b0;
    index_o = '0;
    level_o = '1;
    for (int i = N - 1; i >= 0; i--) begin
      if (valid_i[i] && (!found_o || level_i[i*LW +: LW] <= level_o)) begin
        found_o = 1'b1;
        index_o = IW'(i);
        level_o = level_i[i*LW +: LW];
      end
    end
  end
endmodule

/* logic/nested_vectored_irq_ctrl.sv */
// Purpose: Nested vectored interrupt controller with APB registers
// Assumes: Requests synchronous to clk_i; core acks the presented number
// Notes:   Levels are encoded; fixed exceptions beat every settable one
//
// Functional notes
// [RULE1] Thirty-two external lines, each own vector
// [RULE2] Four settable levels, masking by level
// [RULE3] Reset, NMI, hard fault fixed most urgent
// [RULE4] Line k is number 16+k, vector 0x40+4k
// [RULE5] SVC 11, pendable 14, tick 15 settable
// [RULE6] Port interrupts wired reversed onto lines 28-31
// [RULE7] Enable-set writes ones enable, reads enables
// [RULE8] Enable-clear writes ones disable, reads enables
// [RULE9] Pending-set writes ones pend, reads pending
// [RULE10] Setting already pending line changes nothing
// [RULE11] Disabled lines may still be set pending
// [RULE12] Pending-clear writes ones unpend, reads pending
// [RULE13] Clearing pending leaves active state alone
// [RULE14] Eight priority words, four byte fields each
// [RULE15] Only top two field bits are stored
// [RULE16] Writing 255 reads back 192
// [RULE17] Lower priority value means more urgent
// [RULE18] Most urgent pending enabled wins, beats active
// [RULE19] Ack clears pending, sets active; return clears
`timescale 1ns/1ps
module nested_vectored_irq_ctrl #(
  parameter int unsigned LINES = irq_ctrl_pkg::LINES  // External lines
) (
  input  wire logic        clk_i,         // System clock
  input  wire logic        sys_rst_i,     // Synchronous reset
  input  wire logic        psel_i,        // APB select
  input  wire logic        penable_i,     // APB enable
  input  wire logic        pwrite_i,      // APB write
  input  wire logic [31:0] paddr_i,       // APB address
  input  wire logic [31:0] pwdata_i,      // APB write data
  output logic [31:0]      prdata_o,      // APB read data
  output logic             pready_o,      // APB ready
  output logic             pslverr_o,     // APB error
  input  wire logic [27:0] periph_irq_i,  // Peripheral lines 0..27
  input  wire logic [3:0]  port_irq_i,    // Port 0..3 interrupts
  input  wire logic        nmi_i,         // Non-maskable request
  input  wire logic        hard_fault_i,  // Fault request
  input  wire logic        svc_i,         // Supervisor call request
  input  wire logic        pendable_service_exception_i,      // Pendable service request
  input  wire logic        system_tick_exception_i,     // Tick request
  input  wire logic        exc_ack_i,     // Core enters presented one
  input  wire logic        exc_return_i,  // Core leaves running one
  output logic             exc_req_o,     // Exception presented
  output logic [5:0]       exc_num_o,     // Presented number
  output logic [31:0]      exc_vector_o,  // Presented vector slot
  output logic [2:0]       exc_level_o    // Presented level code
);
  localparam int unsigned NE = irq_ctrl_pkg::NUM_EXC;  // Exceptions
  localparam int unsigned LW = irq_ctrl_pkg::LVL_W;    // Level width
  localparam int unsigned PW = irq_ctrl_pkg::PRIO_W;   // Stored bits
  localparam int unsigned FW = irq_ctrl_pkg::FIELD_W;  // Field width

  // Address decode of a priority word
  function automatic logic prio_hit(input logic [31:0] a);
    logic [31:0] d;
    d = a - irq_ctrl_pkg::PRIO_BASE_ADDR;
    return (a >= irq_ctrl_pkg::PRIO_BASE_ADDR) && (d[1:0] == 2'b00) &&
           ((d >> 2) < irq_ctrl_pkg::PRIO_REGS);
  endfunction

  // Word index of a priority register
  function automatic logic [2:0] prio_index(input logic [31:0] a);
    logic [31:0] d;
    d = (a - irq_ctrl_pkg::PRIO_BASE_ADDR) / irq_ctrl_pkg::PRIO_STEP;
    return d[2:0];
  endfunction

  // Controller state
  logic [LINES-1:0] enable;              // Line enables
  logic [NE-1:0]    pending;             // Pending per number
  logic [NE-1:0]    active;              // Active per number
  logic [PW-1:0]    prio_field [LINES];  // Stored line priorities
  logic [PW-1:0]    sys_prio [3];        // SVC, pendable, tick

  // Register port wires
  logic        wr_stb;  // Write completes this edge
  logic [31:0] rdata;   // Decoded read value
  logic        hit;     // Address mapped

  // Arbitration wires
  logic [NE*LW-1:0] lvl_flat;   // Level of every number
  logic [LINES-1:0] line_req;   // Lines after port wiring
  logic [NE-1:0]    hw_set;     // Hardware pend requests
  logic [NE-1:0]    en_mask;    // Numbers allowed to win
  logic             win_found;  // Some candidate pending
  logic [5:0]       win_idx;    // Candidate number
  logic [LW-1:0]    win_lvl;    // Candidate level
  logic             run_found;  // Something active
  logic [5:0]       run_idx;    // Running number
  logic [LW-1:0]    run_lvl;    // Running level raw
  logic [LW-1:0]    cur_lvl;    // Current masking level
  logic             take;       // Candidate may preempt

  // Write decode per register
  logic wr_en_set;  // Enable set
  logic wr_en_clr;  // Enable clear
  logic wr_pd_set;  // Pending set
  logic wr_pd_clr;  // Pending clear
  logic wr_prio;    // Priority word
  logic wr_sys;     // System priority

  // [RULE6] Reversed port wiring
  assign line_req = {port_irq_i[0], port_irq_i[1], port_irq_i[2], port_irq_i[3], periph_irq_i};

  // Register bus timing
  apb_reg_port u_port (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pwrite_i  (pwrite_i),
    .rdata_i   (rdata),
    .hit_i     (hit),
    .prdata_o  (prdata_o),
    .pready_o  (pready_o),
    .pslverr_o (pslverr_o),
    .wr_stb_o  (wr_stb)
  );

  // Strobes for each writable register
  assign wr_en_set = wr_stb && (paddr_i == irq_ctrl_pkg::ENABLE_SET_ADDR);
  assign wr_en_clr = wr_stb && (paddr_i == irq_ctrl_pkg::ENABLE_CLR_ADDR);
  assign wr_pd_set = wr_stb && (paddr_i == irq_ctrl_pkg::PEND_SET_ADDR);
  assign wr_pd_clr = wr_stb && (paddr_i == irq_ctrl_pkg::PEND_CLR_ADDR);
  assign wr_prio   = wr_stb && prio_hit(paddr_i);
  assign wr_sys    = wr_stb && (paddr_i == irq_ctrl_pkg::SYS_PRIO_ADDR);

  // Read mux and map check
  always_comb begin
    rdata = 32'h00000000;
    hit   = 1'b1;
    // [RULE7] Enable state readback
    if (paddr_i == irq_ctrl_pkg::ENABLE_SET_ADDR ||
        paddr_i == irq_ctrl_pkg::ENABLE_CLR_ADDR) begin
      rdata = enable;
    // [RULE12] Pending state readback
    end else if (paddr_i == irq_ctrl_pkg::PEND_SET_ADDR ||
                 paddr_i == irq_ctrl_pkg::PEND_CLR_ADDR) begin
      rdata = pending[irq_ctrl_pkg::EXC_EXT +: LINES];
    end else if (prio_hit(paddr_i)) begin
      // [RULE15] Low six bits read zero
      for (int b = 0; b < 4; b++) begin
        rdata[b*FW + FW - PW +: PW] = prio_field[4*prio_index(paddr_i) + b];
      end
    end else if (paddr_i == irq_ctrl_pkg::SYS_PRIO_ADDR) begin
      rdata[irq_ctrl_pkg::SVC_BYTE*FW + FW - PW +: PW]     = sys_prio[0];
      rdata[irq_ctrl_pkg::PENDABLE_SERVICE_EXCEPTION_BYTE*FW + FW - PW +: PW]  = sys_prio[1];
      rdata[irq_ctrl_pkg::SYSTEM_TICK_EXCEPTION_BYTE*FW + FW - PW +: PW] = sys_prio[2];
    end else if (paddr_i == irq_ctrl_pkg::STATUS_ADDR) begin
      rdata[irq_ctrl_pkg::STAT_RUN_NUM +: 6]  = run_found ? run_idx : 6'h00;
      rdata[irq_ctrl_pkg::STAT_RUN_LVL +: LW] = cur_lvl;
      rdata[irq_ctrl_pkg::STAT_WIN_NUM +: 6]  = win_idx;
      rdata[irq_ctrl_pkg::STAT_WIN_OK]        = win_found;
    end else begin
      // Unmapped: error answer
      hit = 1'b0;
    end
  end

  // Level code of every exception number
  always_comb begin
    lvl_flat = '1;
    // [RULE3] Fixed levels above all settable
    lvl_flat[irq_ctrl_pkg::EXC_RESET*LW +: LW] = irq_ctrl_pkg::LVL_RESET;
    lvl_flat[irq_ctrl_pkg::EXC_NMI*LW +: LW]   = irq_ctrl_pkg::LVL_NMI;
    lvl_flat[irq_ctrl_pkg::EXC_HARD*LW +: LW]  = irq_ctrl_pkg::LVL_HARD;
    // [RULE5] System exceptions use settable levels
    lvl_flat[irq_ctrl_pkg::EXC_SVC*LW +: LW]     = irq_ctrl_pkg::LVL_CFG_BASE + sys_prio[0];
    lvl_flat[irq_ctrl_pkg::EXC_PENDABLE_SERVICE_EXCEPTION*LW +: LW]  = irq_ctrl_pkg::LVL_CFG_BASE + sys_prio[1];
    lvl_flat[irq_ctrl_pkg::EXC_SYSTEM_TICK_EXCEPTION*LW +: LW] = irq_ctrl_pkg::LVL_CFG_BASE + sys_prio[2];
    // [RULE17] Lower value, lower code, more urgent
    for (int k = 0; k < LINES; k++) begin
      lvl_flat[(irq_ctrl_pkg::EXC_EXT + k)*LW +: LW] = irq_ctrl_pkg::LVL_CFG_BASE + prio_field[k];
    end
  end

  // Hardware pend sources
  always_comb begin
    hw_set = '0;
    hw_set[irq_ctrl_pkg::EXC_NMI]     = nmi_i;
    hw_set[irq_ctrl_pkg::EXC_HARD]    = hard_fault_i;
    hw_set[irq_ctrl_pkg::EXC_SVC]     = svc_i;
    hw_set[irq_ctrl_pkg::EXC_PENDABLE_SERVICE_EXCEPTION]  = pendable_service_exception_i;
    hw_set[irq_ctrl_pkg::EXC_SYSTEM_TICK_EXCEPTION] = system_tick_exception_i;
    // [RULE1] Lines pend while high and not active
    hw_set[irq_ctrl_pkg::EXC_EXT +: LINES] = line_req & ~active[irq_ctrl_pkg::EXC_EXT +: LINES];
  end

  // Only enabled lines compete; system numbers always may
  assign en_mask = {enable, 16'hffff};

  // [RULE18] Pick most urgent pending candidate
  level_arbiter #(.N(NE), .LW(LW), .IW(6)) u_win (
    .valid_i (pending & en_mask),
    .level_i (lvl_flat),
    .found_o (win_found),
    .index_o (win_idx),
    .level_o (win_lvl)
  );

  // Most urgent active one is the running handler
  level_arbiter #(.N(NE), .LW(LW), .IW(6)) u_run (
    .valid_i (active),
    .level_i (lvl_flat),
    .found_o (run_found),
    .index_o (run_idx),
    .level_o (run_lvl)
  );

  // [RULE2] Mask by the running level
  assign cur_lvl = run_found ? run_lvl : irq_ctrl_pkg::LVL_IDLE;
  assign take    = win_found && (win_lvl < cur_lvl);

  // Enable register update
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      enable <= irq_ctrl_pkg::ENABLE_RST;
    end else begin
      // [RULE8] Ones disable, zeros ignored
      // [RULE7] Ones enable, set wins
      enable <= (enable & ~(wr_en_clr ? pwdata_i : 32'h00000000)) |
                (wr_en_set ? pwdata_i : 32'h00000000);
    end
  end

  // Pending update; sets win over clears
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pending <= irq_ctrl_pkg::PEND_RST;
    end else begin
      // [RULE9] Software set pending
      // [RULE10] Or-in leaves pending lines as they are
      // [RULE11] No enable term on the set path
      // [RULE12] Ones remove pending
      // [RULE19] Entry removes pending of taken one
      pending <= (pending & ~((wr_pd_clr ? {pwdata_i, 16'h0000} : 48'h0) |
                              ((exc_ack_i && exc_req_o) ? (48'h1 << exc_num_o) : 48'h0))) |
                 hw_set | (wr_pd_set ? {pwdata_i, 16'h0000} : 48'h0);
    end
  end

  // Active update from core handshake
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      active <= '0;
    end else begin
      // [RULE13] Only entry and return touch active
      // [RULE19] Entry marks active, return clears running
      active <= (active & ~((exc_return_i && run_found) ? (48'h1 << run_idx) : 48'h0)) |
                ((exc_ack_i && exc_req_o) ? (48'h1 << exc_num_o) : 48'h0);
    end
  end

  // Priority field storage
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int k = 0; k < LINES; k++) begin
        prio_field[k] <= irq_ctrl_pkg::PRIO_RST;
      end
      for (int s = 0; s < 3; s++) begin
        sys_prio[s] <= irq_ctrl_pkg::PRIO_RST;
      end
    end else begin
      // [RULE14] Field b of word n is line 4n+b
      // [RULE15] Keep only top two bits
      if (wr_prio) begin
        for (int b = 0; b < 4; b++) begin
          prio_field[4*prio_index(paddr_i) + b] <= pwdata_i[b*FW + FW - PW +: PW];
        end
      end
      if (wr_sys) begin
        sys_prio[0] <= pwdata_i[irq_ctrl_pkg::SVC_BYTE*FW + FW - PW +: PW];
        sys_prio[1] <= pwdata_i[irq_ctrl_pkg::PENDABLE_SERVICE_EXCEPTION_BYTE*FW + FW - PW +: PW];
        sys_prio[2] <= pwdata_i[irq_ctrl_pkg::SYSTEM_TICK_EXCEPTION_BYTE*FW + FW - PW +: PW];
      end
    end
  end

  // Presented exception to the core
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      exc_req_o    <= 1'b0;
      exc_num_o    <= 6'h00;
      exc_vector_o <= 32'h00000000;
      exc_level_o  <= irq_ctrl_pkg::LVL_IDLE;
    end else begin
      // [RULE18] Drop for one cycle after an ack, a return or a register write
      exc_req_o    <= take && !exc_ack_i && !exc_return_i && !wr_stb;
      exc_num_o    <= win_idx;
      // [RULE4] Slot is number times four
      exc_vector_o <= irq_ctrl_pkg::vector_offset(win_idx);
      exc_level_o  <= win_lvl;
    end
  end

  // Checks on the design's own behaviour
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);


  // Ones written to enable-set stick
  enable_set_a: assert property (wr_en_set |=> (enable & $past(pwdata_i)) == $past(pwdata_i)) // [RULE7]
    else $error("enable set lost");

  // Ones written to enable-clear drop
  enable_clear_a: assert property (wr_en_clr && !wr_en_set |=> (enable & $past(pwdata_i)) == 32'h0) // [RULE8]
    else $error("enable clear lost");

  // Ones written to pending-set pend
  pend_set_a: assert property (wr_pd_set |=> (pending[47:16] & $past(pwdata_i)) == $past(pwdata_i)) // [RULE9]
    else $error("pending set lost");

  // Pending clear leaves active alone
  pend_clr_keep_a: assert property (wr_pd_clr && !exc_ack_i && !exc_return_i |=> active == $past(active)) // [RULE13]
    else $error("clear touched active");

  // Unstored priority bits read zero
  prio_read_a: assert property (psel_i && penable_i && !pready_o && !pwrite_i && prio_hit(paddr_i) // [RULE15]
    |=> pready_o && (prdata_o & 32'h3f3f3f3f) == 32'h0)
    else $error("priority low bits not zero");

  // Slot is four times the number
  vector_map_a: assert property (exc_req_o |-> exc_vector_o == {24'h0, exc_num_o, 2'b00}) // [RULE4]
    else $error("vector slot wrong");

  // Request only above running level
  preempt_only_a: assert property (exc_req_o |-> $past(win_lvl < cur_lvl)) // [RULE18]
    else $error("request not more urgent");

  // Entry marks the number active
  ack_active_a: assert property (exc_ack_i && exc_req_o |=> active[$past(exc_num_o)]) // [RULE19]
    else $error("ack did not mark active");

  // Port 0 lands on the top line
  port_order_a: assert property (port_irq_i[0] && !active[47] |=> pending[47]) // [RULE6]
    else $error("port 0 not on line 31");

  // Non-maskable keeps its fixed level
  fixed_level_a: assert property (exc_req_o && exc_num_o == 6'h02 |-> exc_level_o == 3'h1) // [RULE3]
    else $error("nmi level wrong");

  // One wait state, one-cycle ready
  answer_time_a: assert property (psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o)
    else $error("answer timing wrong");
endmodule

/* test/core_model.sv */
// Purpose: Core side model that enters and leaves exceptions
// Assumes: The bench asks for each return; slow mode waits three cycles
// Notes:   Entry is a one-cycle pulse, raised only while a request is seen
`timescale 1ns/1ps
module core_model (
  input  wire logic clk_i,        // System clock
  input  wire logic sys_rst_i,    // Synchronous reset
  input  wire logic auto_i,       // Enter presented exceptions
  input  wire logic slow_i,       // Answer late
  input  wire logic ret_i,        // Leave the running exception
  input  wire logic exc_req_i,    // Exception presented
  output logic      exc_ack_o,    // Entry pulse
  output logic      exc_return_o  // Return pulse
);
  logic [1:0] wait_q;  // Cycles a request has waited
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      exc_ack_o    <= 1'b0;
      exc_return_o <= 1'b0;
      wait_q       <= 2'h0;
    end else begin
      exc_ack_o    <= exc_req_i && auto_i && !exc_ack_o && (!slow_i || wait_q == 2'h3);
      exc_return_o <= ret_i;
      wait_q       <= (exc_req_i && wait_q != 2'h3) ? wait_q + 2'h1 : (exc_req_i ? wait_q : 2'h0);
    end
  end
endmodule

/* test/tb.sv */
// Purpose: Self-checking bench for the interrupt controller
// Assumes: APB master waits on pready; core side is core_model
// Notes:   Expected values come from a bit and integer model
`timescale 1ns/1ps
module tb;
  localparam logic [31:0] ES = irq_ctrl_pkg::ENABLE_SET_ADDR;  // Enable set
  localparam logic [31:0] EC = irq_ctrl_pkg::ENABLE_CLR_ADDR;  // Enable clear
  localparam logic [31:0] PS = irq_ctrl_pkg::PEND_SET_ADDR;    // Pending set
  localparam logic [31:0] PC = irq_ctrl_pkg::PEND_CLR_ADDR;    // Pending clear
  localparam logic [31:0] PB = irq_ctrl_pkg::PRIO_BASE_ADDR;   // Priority base
  logic        clk_i = 0, sys_rst_i = 1, psel = 0, penable = 0, pwrite = 0;  // Clock, reset, APB
  logic [31:0] paddr = 0, pwdata = 0, prdata, exc_vec, r, c;  // APB data, vector, scratch
  logic        pready, pslverr, er, ack, back, exc_req;  // Answers and handshake
  logic [27:0] periph = 0;  // Peripheral lines
  logic [3:0]  port = 0;  // Port lines
  logic        nmi = 0, auto = 0, slow = 0, ret = 0;  // NMI request, core side controls
  logic [3:0]  sx = 0;  // Hard fault, SVC, pendable, tick requests
  logic [5:0]  exc_num;  // Presented number
  logic [2:0]  exc_lvl;  // Presented level
  logic [31:0] m_en;  // Model enables
  int          m_pri [32];  // Model stored priorities
  int          err_count = 0, n_compared = 0, cyc = 0, a, b, w;
  always #5 clk_i = ~clk_i;
  nested_vectored_irq_ctrl uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .periph_irq_i(periph), .port_irq_i(port), .nmi_i(nmi), .hard_fault_i(sx[3]),
    .svc_i(sx[2]), .pendable_service_exception_i(sx[1]), .system_tick_exception_i(sx[0]), .exc_ack_i(ack), .exc_return_i(back),
    .exc_req_o(exc_req), .exc_num_o(exc_num), .exc_vector_o(exc_vec), .exc_level_o(exc_lvl));
  core_model core (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .auto_i(auto), .slow_i(slow), .ret_i(ret),
    .exc_req_i(exc_req), .exc_ack_o(ack), .exc_return_o(back));
  // Count and report one comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // One APB transfer, request held until pready is seen high
  task automatic apb(input logic wr, input logic [31:0] ad, input logic [31:0] d);
    @(posedge clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    r  = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Read and compare under a mask
  task automatic rd(input logic [31:0] ad, input logic [31:0] exp, input logic [31:0] msk, input string what);
    apb(1'b0, ad, 32'h0);
    chk(r & msk, exp, what);
  endtask
  // Wait for a presented exception and compare number, slot and level
  task automatic exc_chk(input int num, input int lvl);
    repeat (2) @(posedge clk_i);
    do @(negedge clk_i); while (exc_req !== 1'b1);
    chk({26'h0, exc_num}, num, "number");
    chk(exc_vec, num * 4, "vector");
    chk({29'h0, exc_lvl}, lvl, "level");
  endtask
  // Ask the core to leave the running exception
  task automatic leave();
    @(posedge clk_i);
    ret <= 1'b1;
    @(posedge clk_i);
    ret <= 1'b0;
  endtask
  // Let the core take the presented exception
  task automatic enter();
    auto <= 1'b1;
    do @(negedge clk_i); while (ack !== 1'b1);
    auto <= 1'b0;
  endtask
  // Most urgent pending enabled line, lowest index on a tie
  function automatic int winner(input logic [31:0] pm);
    int bst;
    bst = -1;
    for (int k = 0; k < 32; k++)
      if (pm[k] && m_en[k] && (bst < 0 || m_pri[k] < m_pri[bst])) bst = k;
    return bst;
  endfunction
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(32));
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    exc_chk(1, 0);
    enter();
    leave();
    for (int i = 0; i < 8; i++) rd(PB + 4 * i, 0, '1, "priority reset");
    rd(ES, 0, '1, "enable reset");
    apb(1'b0, 32'he000e300, 32'h0);
    chk({31'h0, er}, 1, "unmapped");
    m_en = $urandom;
    apb(1'b1, ES, m_en);
    rd(ES, m_en, '1, "enable set");
    c = $urandom;
    apb(1'b1, EC, c);
    m_en &= ~c;
    rd(EC, m_en, '1, "enable clear");
    w = $urandom;
    repeat (2) begin
      apb(1'b1, PS, w);
      rd(PS, w, '1, "pending set");
    end
    c = $urandom;
    apb(1'b1, PC, c);
    rd(PC, w & ~c, '1, "pending clear");
    apb(1'b1, PC, '1);
    for (int i = 0; i < 8; i++) begin
      c = (i == 0) ? '1 : $urandom;
      apb(1'b1, PB + 4 * i, c);
      rd(PB + 4 * i, c & 32'hc0c0c0c0, '1, "priority");
      for (int k = 0; k < 4; k++) m_pri[4 * i + k] = c[8 * k + 6 +: 2];
    end
    m_en = '1;
    apb(1'b1, ES, m_en);
    repeat (6) begin
      a = $urandom % 32;
      b = $urandom % 32;
      apb(1'b1, PS, (32'h1 << a) | (32'h1 << b));
      w = winner((32'h1 << a) | (32'h1 << b));
      exc_chk(16 + w, 3 + m_pri[w]);
      apb(1'b1, PC, '1);
    end
    slow <= 1'b1;
    apb(1'b1, PS, 32'h1 << a);
    exc_chk(16 + a, 3 + m_pri[a]);
    enter();
    rd(PS, 0, '1, "pending after entry");
    apb(1'b1, PS, 32'h1 << a);
    apb(1'b1, PC, 32'h1 << a);
    rd(irq_ctrl_pkg::STATUS_ADDR, 16 + a, 32'h3f, "running");
    leave();
    rd(irq_ctrl_pkg::STATUS_ADDR, 0, 32'h3f, "after return");
    for (int p = 0; p < 4; p++) begin
      @(posedge clk_i);
      port <= 4'h1 << p;
      rd(PS, 32'h1 << (31 - p), '1, "port line");
      port <= 4'h0;
      apb(1'b1, PC, '1);
    end
    a = $urandom % 28;
    periph <= 28'h1 << a;
    rd(PS, 32'h1 << a, '1, "peripheral line");
    periph <= 28'h0;
    apb(1'b1, PC, '1);
    c = $urandom;
    w = c << 8;
    apb(1'b1, irq_ctrl_pkg::SYS_PRIO_ADDR, c);
    rd(irq_ctrl_pkg::SYS_PRIO_ADDR, c & 32'h00c0c0c0, '1, "system priority");
    // Hard fault, then SVC, pendable and tick, one at a time
    for (int s = 0; s < 4; s++) begin
      @(posedge clk_i);
      sx <= 4'h8 >> s;
      @(posedge clk_i);
      sx <= 4'h0;
      exc_chk(s == 0 ? 3 : (s == 1 ? 11 : 12 + s), s == 0 ? 2 : 3 + w[8 * s + 6 +: 2]);
      enter();
      leave();
    end
    @(posedge clk_i);
    nmi <= 1'b1;
    @(posedge clk_i);
    nmi <= 1'b0;
    exc_chk(2, 1);
    give_verdict();
  end
endmodule
